// [design/pmh_pkg.sv]
// pmh_pkg: shared types and constants for the privileged-mode hazard control block.
// assumes a single core clock; the decoder upstream classifies each issued instruction.
package pmh_pkg;

  localparam int PMH_CLK_PERIOD_NS = 10;
  localparam int PMH_PC_W = 32;
  localparam int PMH_WIN_W = 5;

  // entry offsets relative to the handler base; values of our own choosing
  localparam logic [PMH_PC_W-1:0] PMH_ENTRY_RESET = 32'h0000_0000;
  localparam logic [PMH_PC_W-1:0] PMH_ENTRY_INTR = 32'h0000_0100;
  localparam logic [PMH_PC_W-1:0] PMH_ENTRY_TRAP = 32'h0000_0200;
  localparam logic [PMH_PC_W-1:0] PMH_ENTRY_ILLEGAL = 32'h0000_0300;
  localparam logic [PMH_PC_W-1:0] PMH_ENTRY_CALL = 32'h0000_2000;
  localparam logic [PMH_PC_W-1:0] PMH_PC_RESET = 32'h0000_0001;

  // cycle windows: bit n set means forbidden n cycles after the access
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_MEMORY_CTRL_STATUS_REG_VIRT = 5'h1F;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_MEMORY_CTRL_STATUS_REG_RDSELF = 5'h06;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_MEMORY_CTRL_STATUS_REG_VAFORM = 5'h0E;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_MEMORY_CTRL_STATUS_REG_REI = 5'h0F;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_MEMORY_CTRL_STATUS_REG_REISTALL = 5'h03;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_PTBR_VAFORM = 5'h06;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_ITB_TEMP = 5'h0E;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_DCT_TEMP = 5'h02;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_DTB_MBOX = 5'h03;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_DTB_DCWR = 5'h03;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_DTB_TEMP = 5'h0E;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_DTB_SELF = 5'h02;
  localparam logic [PMH_WIN_W-1:0] PMH_WIN_DTB_VIRT = 5'h07;

  typedef enum logic [3:0] {
    PMH_IR_NONE = 4'h0,
    PMH_IR_MEMORY_CTRL_STATUS_REG = 4'h1,
    PMH_IR_VAFORM = 4'h2,
    PMH_IR_PTBR = 4'h3,
    PMH_IR_ITB_ENTRY = 4'h4,
    PMH_IR_ITB_TEMP = 4'h5,
    PMH_IR_DCT_TAG = 4'h6,
    PMH_IR_DCT_TEMP = 4'h7,
    PMH_IR_DCT_CTL = 4'h8,
    PMH_IR_DTB_ENTRY = 4'h9,
    PMH_IR_DTB_TEMP = 4'hA,
    PMH_IR_FAULT_VA = 4'hB
  } pmh_ireg_t;

  // one issued instruction as seen by the control block
  typedef struct packed {
    logic valid;
    logic priv_only;
    logic wr_ireg;
    logic rd_ireg;
    pmh_ireg_t ireg;
    logic ret_exc;
    logic ret_stall;
    logic mbox;
    logic mbox_virt;
    logic load;
    logic phys_mem;
    logic call_priv;
    logic [PMH_PC_W-1:0] pc;
  } pmh_issue_t;

  // entry events and the tag fill busy flag, sampled by the control block
  typedef struct packed {
    logic machine_check_trap;
    logic arithmetic_trap;
    logic mm_fault;
    logic intr;
    logic fill_busy;
  } pmh_event_t;

  // hazard flags, one per checked relation
  typedef struct packed {
    logic memory_ctrl_status_reg_virt;
    logic memory_ctrl_status_reg_rdself;
    logic memory_ctrl_status_reg_vaform;
    logic memory_ctrl_status_reg_rei;
    logic memory_ctrl_status_reg_reistall;
    logic ptbr_vaform;
    logic itb_temp;
    logic dct_fill;
    logic dct_load;
    logic dct_temp;
    logic dct_ctlwr;
    logic dtb_mbox;
    logic dtb_dcwr;
    logic dtb_temp;
    logic dtb_self;
    logic dtb_virt;
  } pmh_hazard_t;

endpackage : pmh_pkg

// [design/pmh_ctrl.sv]
// pmh_ctrl: mode control and issue-window hazard checking for privileged library code.
// assumes one instruction per cycle on the issue port, already decoded; event inputs are
// produced by core logic on clk; drain_done comes from the pipeline after a drain request.
`timescale 1ns/10ps

module pmh_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // issue stream and core events
  input pmh_pkg::pmh_issue_t issue,
  input pmh_pkg::pmh_event_t event_in,
  input wire logic [pmh_pkg::PMH_PC_W-1:0] exc_target,
  input wire logic drain_done,
  // mode and control outputs
  output logic priv_mode,
  output logic imap_en,
  output logic dmap_en,
  output logic intr_accept,
  output logic ireg_move_en,
  output logic phys_bypass,
  output logic drain_req,
  output logic redirect,
  output logic [pmh_pkg::PMH_PC_W-1:0] redirect_pc,
  output logic [pmh_pkg::PMH_PC_W-1:0] fetch_pc,
  output logic [pmh_pkg::PMH_PC_W-1:0] exception_address_reg,
  // hazard report
  output pmh_pkg::pmh_hazard_t hazard,
  output logic hazard_any
);
  import pmh_pkg::*;

  typedef enum logic [2:0] {
    PMH_ST_RUN = 3'b001,
    PMH_ST_DRAIN = 3'b010,
    PMH_ST_DISPATCH = 3'b100
  } pmh_state_t;

  function automatic logic win_hit(input logic [PMH_WIN_W-1:0] hist,
                                   input logic [PMH_WIN_W-1:0] win);
    win_hit = |(hist & win);
  endfunction : win_hit

  pmh_state_t state_reg, state_next;
  logic mode_reg, mode_next;
  logic [PMH_PC_W-1:0] exc_reg, exc_next;
  logic [PMH_PC_W-1:0] entry_reg, entry_next;
  logic [PMH_PC_W-1:0] pc_reg, pc_next;
  logic redir_reg, redir_next;
  logic [PMH_PC_W-1:0] rpc_reg, rpc_next;
  // separate output flops so that no output passes through gates after a register
  logic imap_reg, intr_reg, dmap_reg, drain_reg, hz_any_reg;
  logic tag_open_reg, tag_open_next;
  // history shift registers: bit n = access happened n cycles ago
  logic [PMH_WIN_W-1:0] h_memory_ctrl_status_reg_wr, h_ptbr_wr, h_itb_rd, h_dct_rd, h_dtb_rd;
  logic [PMH_WIN_W-1:0] h_memory_ctrl_status_reg_wr_reg, h_ptbr_wr_reg, h_itb_rd_reg, h_dct_rd_reg, h_dtb_rd_reg;
  pmh_hazard_t hazard_reg, hazard_next;

  wire iv = issue.valid;
  wire wr_memory_ctrl_status_reg = iv && issue.wr_ireg && issue.ireg == PMH_IR_MEMORY_CTRL_STATUS_REG;
  wire wr_ptbr = iv && issue.wr_ireg && issue.ireg == PMH_IR_PTBR;
  wire wr_dctl = iv && issue.wr_ireg && issue.ireg == PMH_IR_DCT_CTL;
  wire wr_dtag = iv && issue.wr_ireg && issue.ireg == PMH_IR_DCT_TAG;
  wire rd_memory_ctrl_status_reg = iv && issue.rd_ireg && issue.ireg == PMH_IR_MEMORY_CTRL_STATUS_REG;
  wire rd_vaform = iv && issue.rd_ireg && issue.ireg == PMH_IR_VAFORM;
  wire rd_itb = iv && issue.rd_ireg && issue.ireg == PMH_IR_ITB_ENTRY;
  wire rd_itbt = iv && issue.rd_ireg && issue.ireg == PMH_IR_ITB_TEMP;
  wire rd_dtag = iv && issue.rd_ireg && issue.ireg == PMH_IR_DCT_TAG;
  wire rd_dtagt = iv && issue.rd_ireg && issue.ireg == PMH_IR_DCT_TEMP;
  wire rd_dtb = iv && issue.rd_ireg && issue.ireg == PMH_IR_DTB_ENTRY;
  wire rd_dtbt = iv && issue.rd_ireg && issue.ireg == PMH_IR_DTB_TEMP;
  wire is_rei = iv && issue.ret_exc;
  wire is_stall = iv && issue.ret_stall;
  wire is_mbox = iv && issue.mbox;
  wire is_virt = iv && issue.mbox_virt;

  // bit 0 of each history is the current cycle
  assign h_memory_ctrl_status_reg_wr = {h_memory_ctrl_status_reg_wr_reg[PMH_WIN_W-2:0], wr_memory_ctrl_status_reg};
  assign h_ptbr_wr = {h_ptbr_wr_reg[PMH_WIN_W-2:0], wr_ptbr};
  assign h_itb_rd = {h_itb_rd_reg[PMH_WIN_W-2:0], rd_itb};
  assign h_dct_rd = {h_dct_rd_reg[PMH_WIN_W-2:0], rd_dtag};
  assign h_dtb_rd = {h_dtb_rd_reg[PMH_WIN_W-2:0], rd_dtb};

  // all checks apply to any valid issue in either mode, privileged or not; windows from the package
  assign hazard_next.memory_ctrl_status_reg_virt = is_virt && win_hit(h_memory_ctrl_status_reg_wr, PMH_WIN_MEMORY_CTRL_STATUS_REG_VIRT);
  assign hazard_next.memory_ctrl_status_reg_rdself = rd_memory_ctrl_status_reg && win_hit(h_memory_ctrl_status_reg_wr, PMH_WIN_MEMORY_CTRL_STATUS_REG_RDSELF);
  assign hazard_next.memory_ctrl_status_reg_vaform = rd_vaform && win_hit(h_memory_ctrl_status_reg_wr, PMH_WIN_MEMORY_CTRL_STATUS_REG_VAFORM);
  assign hazard_next.memory_ctrl_status_reg_rei = is_rei && win_hit(h_memory_ctrl_status_reg_wr, PMH_WIN_MEMORY_CTRL_STATUS_REG_REI);
  assign hazard_next.memory_ctrl_status_reg_reistall = is_stall && win_hit(h_memory_ctrl_status_reg_wr, PMH_WIN_MEMORY_CTRL_STATUS_REG_REISTALL);
  assign hazard_next.ptbr_vaform = rd_vaform && win_hit(h_ptbr_wr, PMH_WIN_PTBR_VAFORM);
  assign hazard_next.itb_temp = rd_itbt && win_hit(h_itb_rd, PMH_WIN_ITB_TEMP);
  // fill flag comes from core logic on clk, so it is judged in the read's own cycle
  assign hazard_next.dct_fill = rd_dtag && event_in.fill_busy;
  assign hazard_next.dct_load = rd_dtag && iv && issue.load;
  assign hazard_next.dct_temp = rd_dtagt && win_hit(h_dct_rd, PMH_WIN_DCT_TEMP);
  assign hazard_next.dct_ctlwr = wr_dctl && (tag_open_reg || rd_dtag);
  assign hazard_next.dtb_mbox = is_mbox && win_hit(h_dtb_rd, PMH_WIN_DTB_MBOX);
  assign hazard_next.dtb_dcwr = (wr_dctl || wr_dtag) && win_hit(h_dtb_rd, PMH_WIN_DTB_DCWR);
  assign hazard_next.dtb_temp = rd_dtbt && win_hit(h_dtb_rd, PMH_WIN_DTB_TEMP);
  assign hazard_next.dtb_self = rd_dtb && win_hit(h_dtb_rd, PMH_WIN_DTB_SELF);
  assign hazard_next.dtb_virt = is_virt && win_hit(h_dtb_rd, PMH_WIN_DTB_VIRT);
  // open from a tag read until the matching temp read
  assign tag_open_next = rd_dtagt ? 1'b0 : (rd_dtag ? 1'b1 : tag_open_reg);

  // mode control
  wire intr_ok = event_in.intr && !mode_reg;
  wire illegal = iv && issue.priv_only && !mode_reg;
  wire call = iv && issue.call_priv;
  wire entry_ev = event_in.machine_check_trap || event_in.arithmetic_trap || event_in.mm_fault || intr_ok ||
                  illegal || call;
  wire do_rei = is_rei && mode_reg;
  logic [PMH_PC_W-1:0] entry_sel;
  assign entry_sel = illegal ? PMH_ENTRY_ILLEGAL :
                     (event_in.machine_check_trap || event_in.arithmetic_trap || event_in.mm_fault) ? PMH_ENTRY_TRAP :
                     intr_ok ? PMH_ENTRY_INTR : PMH_ENTRY_CALL;

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    exc_next = exc_reg;
    entry_next = entry_reg;
    pc_next = iv ? issue.pc : pc_reg;
    redir_next = 1'b0;
    rpc_next = rpc_reg;
    case (state_reg)
      PMH_ST_RUN: begin
        if (entry_ev) begin
          state_next = PMH_ST_DRAIN;
          entry_next = entry_sel;
          // pc saved is the faulting or following instruction
          exc_next = call ? issue.pc + 32'h0000_0004 : (iv ? issue.pc : pc_reg);
        end else if (do_rei) begin
          redir_next = 1'b1;
          rpc_next = {exc_target[PMH_PC_W-1:1], 1'b0};
          mode_next = exc_target[0];
        end
      end
      PMH_ST_DRAIN: begin
        if (drain_done) begin
          state_next = PMH_ST_DISPATCH;
        end
      end
      PMH_ST_DISPATCH: begin
        state_next = PMH_ST_RUN;
        mode_next = 1'b1;
        redir_next = 1'b1;
        rpc_next = entry_reg;
      end
      default: begin
        state_next = PMH_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= PMH_ST_DISPATCH;
      mode_reg <= 1'b1;
      exc_reg <= '0;
      entry_reg <= PMH_ENTRY_RESET;
      pc_reg <= PMH_PC_RESET;
      redir_reg <= 1'b0;
      rpc_reg <= '0;
      imap_reg <= 1'b0;
      intr_reg <= 1'b0;
      dmap_reg <= 1'b1;
      drain_reg <= 1'b0;
      hz_any_reg <= 1'b0;
      tag_open_reg <= 1'b0;
      h_memory_ctrl_status_reg_wr_reg <= '0;
      h_ptbr_wr_reg <= '0;
      h_itb_rd_reg <= '0;
      h_dct_rd_reg <= '0;
      h_dtb_rd_reg <= '0;
      hazard_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      exc_reg <= exc_next;
      entry_reg <= entry_next;
      pc_reg <= pc_next;
      redir_reg <= redir_next;
      rpc_reg <= rpc_next;
      imap_reg <= !mode_next;
      intr_reg <= !mode_next;
      dmap_reg <= 1'b1;
      drain_reg <= state_next == PMH_ST_DRAIN;
      hz_any_reg <= |hazard_next;
      tag_open_reg <= tag_open_next;
      h_memory_ctrl_status_reg_wr_reg <= h_memory_ctrl_status_reg_wr;
      h_ptbr_wr_reg <= h_ptbr_wr;
      h_itb_rd_reg <= h_itb_rd;
      h_dct_rd_reg <= h_dct_rd;
      h_dtb_rd_reg <= h_dtb_rd;
      hazard_reg <= hazard_next;
    end
  end

  // outputs all from flops; fault va reads are software's duty, not checked here
  assign priv_mode = mode_reg;
  assign imap_en = imap_reg;
  assign dmap_en = dmap_reg;
  assign intr_accept = intr_reg;
  assign ireg_move_en = mode_reg;
  assign phys_bypass = mode_reg;
  assign drain_req = drain_reg;
  assign redirect = redir_reg;
  assign redirect_pc = rpc_reg;
  assign fetch_pc = {pc_reg[PMH_PC_W-1:1], 1'b0};
  assign exception_address_reg = exc_reg;
  assign hazard = hazard_reg;
  assign hazard_any = hz_any_reg;

endmodule : pmh_ctrl

// [tb/pmh_ctrl_monitor.sv]
// pmh_ctrl_monitor: port-level checks on mode control and hazard flags of pmh_ctrl.
// assumes one core clock and the async active-high reset of the block.
`timescale 1ns/10ps
module pmh_ctrl_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // block inputs
  input pmh_pkg::pmh_issue_t issue,
  input pmh_pkg::pmh_event_t event_in,
  input wire logic [pmh_pkg::PMH_PC_W-1:0] exc_target,
  input wire logic drain_done,
  // block outputs
  input wire logic priv_mode,
  input wire logic imap_en,
  input wire logic dmap_en,
  input wire logic intr_accept,
  input wire logic ireg_move_en,
  input wire logic phys_bypass,
  input wire logic drain_req,
  input wire logic redirect,
  input wire logic [pmh_pkg::PMH_PC_W-1:0] redirect_pc,
  input wire logic [pmh_pkg::PMH_PC_W-1:0] fetch_pc,
  input wire logic [pmh_pkg::PMH_PC_W-1:0] exception_address_reg,
  input pmh_pkg::pmh_hazard_t hazard,
  input wire logic hazard_any
);
  import pmh_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // entry events win over a return, so return checks need a quiet cycle
  wire quiet = !(event_in.machine_check_trap | event_in.arithmetic_trap | event_in.mm_fault | event_in.intr);
  AST_MAP: assert property (imap_en == !priv_mode && dmap_en)
    else $error("mapping enables do not follow the mode");
  AST_INTR: assert property (intr_accept == !priv_mode)
    else $error("interrupts accepted in privileged mode");
  AST_PRIV_OPS: assert property (ireg_move_en == priv_mode && phys_bypass == priv_mode)
    else $error("privileged operations enabled outside the mode");
  AST_PC_ALIGN: assert property (fetch_pc[0] == 1'b0)
    else $error("fetch pc carries the mode bit");
  AST_MEMORY_CTRL_STATUS_REG_VIRT: assert property ((issue.valid && issue.wr_ireg && issue.ireg == PMH_IR_MEMORY_CTRL_STATUS_REG)
    ##4 (issue.valid && issue.mbox_virt) |=> hazard.memory_ctrl_status_reg_virt)
    else $error("late virtual op after control write not flagged");
  AST_DTB_SELF: assert property ((issue.valid && issue.rd_ireg && issue.ireg == PMH_IR_DTB_ENTRY)
    ##1 (issue.valid && issue.rd_ireg && issue.ireg == PMH_IR_DTB_ENTRY) |=> hazard.dtb_self)
    else $error("back to back entry read not flagged");
  AST_HZ_ANY: assert property (hazard_any == (|hazard))
    else $error("summary flag differs from hazard vector");
  // a cycle right after a drain is the dispatch cycle, in which issue is not taken
  AST_RETURN: assert property (issue.valid && issue.ret_exc && priv_mode && quiet && !drain_req
    && !$past(drain_req)
    |=> redirect && redirect_pc == ($past(exc_target) & 32'hFFFF_FFFE)
    && {31'h0, priv_mode} == ($past(exc_target) & 32'h1))
    else $error("return did not jump to saved address");
  AST_ENTER: assert property (!priv_mode && event_in.intr && !drain_req && !redirect
    && !$past(drain_req)
    |=> drain_req)
    else $error("interrupt did not start a drain");
  AST_DISPATCH: assert property (drain_req && drain_done |-> ##2 (redirect && priv_mode))
    else $error("handler not dispatched after drain");
  AST_ILLEGAL: assert property (issue.valid && issue.priv_only && !priv_mode && quiet && !drain_req
    && !$past(drain_req)
    |-> ##[1:40] (redirect && redirect_pc == PMH_ENTRY_ILLEGAL))
    else $error("privileged op outside the mode not trapped");
endmodule : pmh_ctrl_monitor

bind pmh_ctrl pmh_ctrl_monitor u_mon (.*);

// [tb/pmh_pipe_model.sv]
// pmh_pipe_model: far-side pipeline answering drain requests, promptly or slowly.
// assumes drain_req is a level held until drain_done has been taken.
`timescale 1ns/10ps
module pmh_pipe_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // drain handshake
  input wire logic drain_req,
  input wire logic slow,
  output logic drain_done
);
  logic [2:0] wait_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) wait_reg <= 3'h0;
    else if (!drain_req) wait_reg <= 3'h0;
    else if (wait_reg != 3'h7) wait_reg <= wait_reg + 3'h1;
  end
  // slow mode stands for a long fill still in flight when the drain starts
  assign drain_done = drain_req && (wait_reg >= (slow ? 3'h4 : 3'h1));
endmodule : pmh_pipe_model

// [tb/pmh_ctrl_bench.sv]
// pmh_ctrl_bench: self-checking bench for pmh_ctrl with the pipeline model as far side.
// assumes the bind in pmh_ctrl_monitor attaches the checker.
`timescale 1ns/10ps
module pmh_ctrl_bench;
  import pmh_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic drain_done, priv_mode, imap_en, dmap_en, intr_accept, ireg_move_en;
  logic phys_bypass, drain_req, redirect, hazard_any;
  logic [PMH_PC_W-1:0] exc_target = 32'h1;
  logic [PMH_PC_W-1:0] redirect_pc, fetch_pc, exception_address_reg;
  pmh_issue_t issue = '0;
  pmh_event_t event_in = '0;
  pmh_hazard_t hazard, seen;
  logic clr_seen = 1'b0;
  int fail_count = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  pmh_ctrl u_dut (.*);
  pmh_pipe_model u_pipe (.clk(clk), .reset(reset), .drain_req(drain_req), .slow(slow),
    .drain_done(drain_done));
  // collect one-cycle hazard pulses at the settled half of the cycle
  always @(negedge clk) seen <= clr_seen ? '0 : (seen | hazard);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // k: 1 write, 2 read, 3 memory op, 4 virtual memory op, 5 return, 6 stall return, 7 call
  function automatic pmh_issue_t op(int k, pmh_ireg_t r);
    pmh_issue_t i;
    i = '0;
    i.valid = 1'b1;
    i.pc = 32'h0000_1001;
    i.ireg = r;
    i.wr_ireg = (k == 1);
    i.rd_ireg = (k == 2);
    i.mbox = (k == 3 || k == 4);
    i.mbox_virt = (k == 4);
    i.ret_exc = (k == 5);
    i.ret_stall = (k == 6);
    i.call_priv = (k == 7);
    i.priv_only = (k inside {1, 2, 5, 6});
    return i;
  endfunction : op

  function automatic pmh_hazard_t hz(int b);
    return (b < 0) ? '0 : pmh_hazard_t'(16'h1 << b);
  endfunction : hz

  task automatic pair(pmh_issue_t a, int gap, pmh_issue_t b, pmh_hazard_t exp);
    clr_seen <= 1'b1;
    issue <= a;
    @(posedge clk);
    clr_seen <= 1'b0;
    issue <= '0;
    repeat (gap - 1) @(posedge clk);
    issue <= b;
    @(posedge clk);
    issue <= '0;
    repeat (3) @(posedge clk);
    check("hazard", exp, seen);
    repeat (6) @(posedge clk);
  endtask : pair

  task automatic wait_redir(logic [31:0] exp);
    int n;
    n = 0;
    #1;
    while (redirect !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    if (redirect !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    check("redirect_pc", exp, redirect_pc);
    @(posedge clk);
  endtask : wait_redir

  task automatic send(pmh_issue_t a);
    issue <= a;
    @(posedge clk);
    issue <= '0;
  endtask : send

  task automatic hazard_windows();
    pmh_issue_t t;
    pair(op(1, PMH_IR_MEMORY_CTRL_STATUS_REG), 4, op(4, PMH_IR_NONE), hz(15));
    pair(op(1, PMH_IR_MEMORY_CTRL_STATUS_REG), 5, op(4, PMH_IR_NONE), hz(-1));
    pair(op(1, PMH_IR_MEMORY_CTRL_STATUS_REG), 2, op(2, PMH_IR_MEMORY_CTRL_STATUS_REG), hz(14));
    pair(op(1, PMH_IR_MEMORY_CTRL_STATUS_REG), 3, op(2, PMH_IR_VAFORM), hz(13));
    pair(op(1, PMH_IR_MEMORY_CTRL_STATUS_REG), 3, op(5, PMH_IR_NONE), hz(12));
    pair(op(1, PMH_IR_MEMORY_CTRL_STATUS_REG), 1, op(6, PMH_IR_NONE), hz(11));
    pair(op(1, PMH_IR_PTBR), 2, op(2, PMH_IR_VAFORM), hz(10));
    pair(op(1, PMH_IR_PTBR), 3, op(2, PMH_IR_VAFORM), hz(-1));
    pair(op(2, PMH_IR_ITB_ENTRY), 3, op(2, PMH_IR_ITB_TEMP), hz(9));
    pair(op(2, PMH_IR_DCT_TAG), 1, op(2, PMH_IR_DCT_TEMP), hz(6));
    pair(op(2, PMH_IR_DCT_TAG), 2, op(1, PMH_IR_DCT_CTL), hz(5));
    pair(op(2, PMH_IR_DCT_TAG), 2, op(2, PMH_IR_DCT_TEMP), hz(-1));
    pair(op(2, PMH_IR_DTB_ENTRY), 1, op(3, PMH_IR_NONE), hz(4));
    pair(op(2, PMH_IR_DTB_ENTRY), 1, op(1, PMH_IR_DCT_TAG), hz(3));
    pair(op(2, PMH_IR_DTB_ENTRY), 3, op(2, PMH_IR_DTB_TEMP), hz(2));
    pair(op(2, PMH_IR_DTB_ENTRY), 1, op(2, PMH_IR_DTB_ENTRY), hz(1));
    pair(op(2, PMH_IR_DTB_ENTRY), 2, op(4, PMH_IR_NONE), hz(0));
    // a load slotted beside the tag read in the same issue cycle
    t = op(2, PMH_IR_DCT_TAG);
    t.load = 1'b1;
    pair(t, 1, '0, hz(7));
    event_in.fill_busy <= 1'b1;
    repeat (3) @(posedge clk);
    pair(op(2, PMH_IR_DCT_TAG), 1, '0, hz(8));
    event_in.fill_busy <= 1'b0;
  endtask : hazard_windows

  task automatic ret_user();
    exc_target <= 32'h0000_4000;
    send(op(5, PMH_IR_NONE));
    wait_redir(32'h0000_4000);
    check("mode", 32'h0, priv_mode);
  endtask : ret_user

  task automatic mode_walk();
    pmh_issue_t c;
    ret_user();
    check("imap", 32'h1, imap_en);
    check("intr", 32'h1, intr_accept);
    check("move", 32'h0, ireg_move_en);
    slow <= 1'b1;
    send(op(2, PMH_IR_MEMORY_CTRL_STATUS_REG));
    wait_redir(PMH_ENTRY_ILLEGAL);
    check("mode", 32'h1, priv_mode);
    ret_user();
    c = op(7, PMH_IR_NONE);
    c.pc = 32'h0000_5000;
    send(c);
    wait_redir(PMH_ENTRY_CALL);
    check("exception_address_reg", 32'h0000_5004, exception_address_reg);
    check("phys", 32'h1, phys_bypass);
    // one-cycle trap request; the handler then reads the faulting address
    event_in.arithmetic_trap <= 1'b1;
    @(posedge clk);
    event_in.arithmetic_trap <= 1'b0;
    wait_redir(PMH_ENTRY_TRAP);
    check("trap mode", 32'h1, priv_mode);
    send(op(2, PMH_IR_FAULT_VA));
    event_in.intr <= 1'b1;
    repeat (4) @(posedge clk);
    check("drain", 32'h0, drain_req);
    event_in.intr <= 1'b0;
    ret_user();
    slow <= 1'b0;
    event_in.intr <= 1'b1;
    wait_redir(PMH_ENTRY_INTR);
    event_in.intr <= 1'b0;
    check("mode", 32'h1, priv_mode);
  endtask : mode_walk

  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wait_redir(PMH_ENTRY_RESET);
    check("reset mode", 32'h1, priv_mode);
    hazard_windows();
    check("fetch_pc", 32'h0000_1000, fetch_pc);
    mode_walk();
    complete_run();
  end
endmodule : pmh_ctrl_bench
